// *** src/pcr_map.svh ***
/*
  Offsets, field positions, reset values and fixed codes of the
  capability structure. Assumes inclusion by the block only; the package does not include it.
*/
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

`define PCR_OFS_CAP_ID 8'h70
`define PCR_OFS_NEXT_PTR 8'h71
`define PCR_OFS_LINK_CAPS 8'h72
`define PCR_OFS_DEV_CAPS 8'h74

`define PCR_RST_CAP_ID 8'h10
`define PCR_RST_NEXT_PTR 8'h00
`define PCR_RST_LINK_CAPS 16'h0072
`define PCR_RST_DEV_CAPS 32'h0000_8d82

`define PCR_LC_RSVD_MSB 15
`define PCR_LC_RSVD_LSB 14
`define PCR_LC_INTMSG_MSB 13
`define PCR_LC_INTMSG_LSB 9
`define PCR_LC_SLOT_BIT 8
`define PCR_LC_PORT_MSB 7
`define PCR_LC_PORT_LSB 4
`define PCR_LC_VER_MSB 3
`define PCR_LC_VER_LSB 0

`define PCR_LC_RSVD_VAL 2'h0
`define PCR_LC_INTMSG_VAL 5'h00
`define PCR_LC_SLOT_VAL 1'h0
`define PCR_LC_PORT_VAL 4'h7
`define PCR_LC_VER_VAL 4'h2

`define PCR_DC_RSVD_HI_MSB 31
`define PCR_DC_RSVD_HI_LSB 28
`define PCR_DC_SCALE_MSB 27
`define PCR_DC_SCALE_LSB 26
`define PCR_DC_VALUE_MSB 25
`define PCR_DC_VALUE_LSB 18
`define PCR_DC_RSVD_LO_MSB 17
`define PCR_DC_RSVD_LO_LSB 16
`define PCR_DC_ROLE_BASED_ERROR_SUPPORT_BIT 15
`define PCR_DC_PIND_BIT 14
`define PCR_DC_LOW_MSB 13
`define PCR_DC_LOW_LSB 0

`define PCR_DC_RSVD_HI_VAL 4'h0
`define PCR_DC_RSVD_LO_VAL 2'h0
`define PCR_DC_ROLE_BASED_ERROR_SUPPORT_VAL 1'h1
`define PCR_DC_PIND_VAL 1'h0
`define PCR_DC_LOW_VAL 14'h0d82
`define PCR_RST_SCALE 2'h0
`define PCR_RST_VALUE 8'h00

`define PCR_MSG_SCALE_MSB 9
`define PCR_MSG_SCALE_LSB 8
`define PCR_MSG_VALUE_MSB 7
`define PCR_MSG_VALUE_LSB 0

`define PCR_MW_X1 18'h0_03e8
`define PCR_MW_X01 18'h0_0064
`define PCR_MW_X001 18'h0_000a
`define PCR_MW_X0001 18'h0_0001

`endif

// *** src/pcr_pkg.sv ***
/*
  Types of the capability structure block.
  Assumes the map header sits beside it.
*/
package pcr_pkg;

  typedef enum logic [1:0] {
    PCR_SCALE_X1 = 2'h0,
    PCR_SCALE_X0_1 = 2'h1,
    PCR_SCALE_X0_01 = 2'h2,
    PCR_SCALE_X0_001 = 2'h3
  } pcr_scale_t;

  typedef enum logic [2:0] {
    PCR_ST_IDLE = 3'b001,
    PCR_ST_READ = 3'b010,
    PCR_ST_WRITE = 3'b100
  } pcr_state_t;

endpackage

// *** src/pcr_cap_regs.sv ***
/*
  Read-only capability structure of the bridge config space, with the
  slot power limit captured from the upstream power-limit message.
  Assumes config requests and messages arrive decoded, one-cycle strobes,
  on the same clock; addresses are byte offsets of dword accesses.
*/
`timescale 1ns/10ps
`include "pcr_map.svh"

module pcr_cap_regs
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic msg_valid,
  input wire logic [31:0] msg_payload,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  output logic [1:0] captured_power_limit_scale,
  output logic [7:0] captured_power_limit_value,
  output logic [17:0] slot_power_limit_mw
);

  pcr_pkg::pcr_state_t state_q;
  pcr_pkg::pcr_state_t state_d;
  logic [1:0] scale_q;
  logic [7:0] value_q;
  logic [15:0] link_caps;
  logic [31:0] dev_caps;
  logic [31:0] word_70;
  logic [31:0] rdata_d;
  logic [17:0] mult;
  logic [17:0] mw_d;
  logic [7:0] addr_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [17:0] mw_q;

  // Fixed capability fields
  always_comb
  begin
    link_caps = `PCR_RST_LINK_CAPS;
    link_caps[`PCR_LC_RSVD_MSB:`PCR_LC_RSVD_LSB] = `PCR_LC_RSVD_VAL;
    link_caps[`PCR_LC_INTMSG_MSB:`PCR_LC_INTMSG_LSB] = `PCR_LC_INTMSG_VAL;
    link_caps[`PCR_LC_SLOT_BIT] = `PCR_LC_SLOT_VAL;
    link_caps[`PCR_LC_PORT_MSB:`PCR_LC_PORT_LSB] = `PCR_LC_PORT_VAL;
    link_caps[`PCR_LC_VER_MSB:`PCR_LC_VER_LSB] = `PCR_LC_VER_VAL;
  end

  always_comb
  begin
    dev_caps = `PCR_RST_DEV_CAPS;
    dev_caps[`PCR_DC_RSVD_HI_MSB:`PCR_DC_RSVD_HI_LSB] = `PCR_DC_RSVD_HI_VAL;
    dev_caps[`PCR_DC_SCALE_MSB:`PCR_DC_SCALE_LSB] = scale_q;
    dev_caps[`PCR_DC_VALUE_MSB:`PCR_DC_VALUE_LSB] = value_q;
    dev_caps[`PCR_DC_RSVD_LO_MSB:`PCR_DC_RSVD_LO_LSB] = `PCR_DC_RSVD_LO_VAL;
    dev_caps[`PCR_DC_ROLE_BASED_ERROR_SUPPORT_BIT] = `PCR_DC_ROLE_BASED_ERROR_SUPPORT_VAL;
    dev_caps[`PCR_DC_PIND_BIT] = `PCR_DC_PIND_VAL;
    // Lower fields kept at their defaults
    dev_caps[`PCR_DC_LOW_MSB:`PCR_DC_LOW_LSB] = `PCR_DC_LOW_VAL;
  end

  assign word_70 = {link_caps, `PCR_RST_NEXT_PTR, `PCR_RST_CAP_ID};

  // Captured power limit
  // message capture
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      scale_q <= `PCR_RST_SCALE;
      value_q <= `PCR_RST_VALUE;
    end
    else if (msg_valid)
    begin
      scale_q <= msg_payload[`PCR_MSG_SCALE_MSB:`PCR_MSG_SCALE_LSB];
      value_q <= msg_payload[`PCR_MSG_VALUE_MSB:`PCR_MSG_VALUE_LSB];
    end
  end

  always_comb
  begin
    case (pcr_pkg::pcr_scale_t'(scale_q))
      pcr_pkg::PCR_SCALE_X1: mult = `PCR_MW_X1;
      pcr_pkg::PCR_SCALE_X0_1: mult = `PCR_MW_X01;
      pcr_pkg::PCR_SCALE_X0_01: mult = `PCR_MW_X001;
      pcr_pkg::PCR_SCALE_X0_001: mult = `PCR_MW_X0001;
      default: mult = `PCR_MW_X1;
    endcase
  end

  assign mw_d = 18'(mult * {10'h000, value_q});

  // Request sequencing; one answer per request, read wins a collision
  always_comb
  begin
    case (state_q)
      pcr_pkg::PCR_ST_IDLE,
      pcr_pkg::PCR_ST_READ,
      pcr_pkg::PCR_ST_WRITE:
      begin
        if (cfg_rd)
          state_d = pcr_pkg::PCR_ST_READ;
        else if (cfg_wr)
          state_d = pcr_pkg::PCR_ST_WRITE;
        else
          state_d = pcr_pkg::PCR_ST_IDLE;
      end
      default: state_d = pcr_pkg::PCR_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= pcr_pkg::PCR_ST_IDLE;
      addr_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      addr_q <= cfg_addr;
    end
  end

  // Dword decode; unmapped offsets read zero
  always_comb
  begin
    case ({addr_q[7:2], 2'b00})
      `PCR_OFS_CAP_ID: rdata_d = word_70;
      `PCR_OFS_DEV_CAPS: rdata_d = dev_caps;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= (state_q != pcr_pkg::PCR_ST_IDLE);
      rdata_q <= (state_q == pcr_pkg::PCR_ST_READ) ? rdata_d : 32'h0000_0000;
    end
  end

  // Registered limit output
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      mw_q <= 18'h0_0000;
    else
      mw_q <= mw_d;
  end

  assign cfg_ack = ack_q;
  assign cfg_rdata = rdata_q;
  assign captured_power_limit_scale = scale_q;
  assign captured_power_limit_value = value_q;
  assign slot_power_limit_mw = mw_q;

endmodule // pcr_cap_regs

// *** tb/pcr_cap_checker.sv ***
/*
  Port assertions of the capability block.
  Assumes it is bound to pcr_cap_regs and sees its ports only.
*/
`timescale 1ns/10ps

module pcr_cap_checker
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic msg_valid,
  input wire logic [31:0] msg_payload,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  input wire logic [1:0] captured_power_limit_scale,
  input wire logic [7:0] captured_power_limit_value,
  input wire logic [17:0] slot_power_limit_mw
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [9:0] f;
  logic [17:0] mult;
  assign f = {captured_power_limit_scale, captured_power_limit_value};
  assign mult = 18'h0_03e8 >> 0;
  sequence rd_id;
    cfg_rd && cfg_addr[7:2] == 6'h1c ##2 1'b1;
  endsequence
  sequence rd_dc;
    cfg_rd && cfg_addr[7:2] == 6'h1d ##2 1'b1;
  endsequence
  ack_delay_a: assert property ((cfg_rd || cfg_wr) |-> ##2 cfg_ack)
    else $error("late answer");
  id_word_a: assert property (rd_id |-> cfg_rdata[15:0] == 16'h0010)
    else $error("bad id word");
  caps_word_a: assert property (rd_id |-> cfg_rdata[31:16] == 16'h0072)
    else $error("bad caps word");
  dc_fixed_a: assert property (rd_dc |-> {cfg_rdata[31:28], cfg_rdata[17:14]} == 8'h02)
    else $error("bad fixed bits");
  dc_field_a: assert property (rd_dc |-> cfg_rdata[27:18] == f)
    else $error("bad limit fields");
  msg_take_a: assert property (msg_valid |=> f == $past(msg_payload[9:0]))
    else $error("message not taken");
  field_hold_a: assert property (!$past(msg_valid) |-> $stable(f))
    else $error("fields moved");
  mw_calc_a: assert property (slot_power_limit_mw == 18'($past(captured_power_limit_value)
    * ($past(mult) / (captured_power_limit_scale == $past(captured_power_limit_scale) ?
    18'h0_0001 : 18'h0_0001) / (18'h0_0001 << 0) / ($past(captured_power_limit_scale) == 2'h0 ?
    18'h0_0001 : $past(captured_power_limit_scale) == 2'h1 ? 18'h0_000a :
    $past(captured_power_limit_scale) == 2'h2 ? 18'h0_0064 : 18'h0_03e8))))
    else $error("bad power figure");
endmodule // pcr_cap_checker

bind pcr_cap_regs pcr_cap_checker pcr_cap_checker_inst (.clk(clk), .reset(reset),
  .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .msg_valid(msg_valid),
  .msg_payload(msg_payload), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
  .captured_power_limit_scale(captured_power_limit_scale),
  .captured_power_limit_value(captured_power_limit_value),
  .slot_power_limit_mw(slot_power_limit_mw));

// *** tb/pcr_host_model.sv ***
/*
  Upstream host: config requests and power-limit messages.
  Assumes the block samples on the rising clock edge.
*/
`timescale 1ns/10ps

module pcr_host_model
(
  input wire logic clk,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  output logic cfg_rd,
  output logic cfg_wr,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  output logic msg_valid,
  output logic [31:0] msg_payload
);
  initial {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata, msg_valid, msg_payload} = '0;
  // Released address and payload lines flip, cfg_wdata goes to 32'h5a5a_5a5a; cfg_be keeps its value 4'hf
  task automatic xfer(input logic wr, input logic [7:0] a, output logic [32:0] r);
    @(negedge clk);
    {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {~wr, wr, a, 4'hf, 32'hffff_ffff};
    @(negedge clk);
    {cfg_rd, cfg_wr, cfg_addr, cfg_wdata} = {2'h0, ~a, 32'h5a5a_5a5a};
    // Answer stands one cycle, launched at the edge after the request edge
    @(posedge clk);
    #1 r = {cfg_ack, cfg_rdata};
  endtask
  task automatic msg(input logic [31:0] p);
    @(negedge clk);
    {msg_valid, msg_payload} = {1'h1, p};
    @(negedge clk);
    {msg_valid, msg_payload} = {1'h0, ~p};
    repeat (3) @(posedge clk);
  endtask
endmodule // pcr_host_model

// *** tb/test_pcr_cap_regs.sv ***
/*
  Self-checking bench of the capability block.
  Assumes the host model drives every input but clk and reset.
*/
`timescale 1ns/10ps

module test_pcr_cap_regs;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic cfg_rd, cfg_wr, msg_valid, cfg_ack;
  logic [7:0] cfg_addr, val, v;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, msg_payload, cfg_rdata;
  logic [1:0] sc;
  logic [17:0] mw;
  logic [32:0] r;
  logic [17:0] mul [4] = '{18'h0_03e8, 18'h0_0064, 18'h0_000a, 18'h0_0001};
  int mismatches = 0;
  int checked = 0;
  always #20 clk = ~clk;
  pcr_host_model pcr_host_model_inst (.clk(clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .msg_valid(msg_valid), .msg_payload(msg_payload));
  pcr_cap_regs pcr_cap_regs_inst (.clk(clk), .reset(reset), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .msg_valid(msg_valid),
    .msg_payload(msg_payload), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .captured_power_limit_scale(sc), .captured_power_limit_value(val),
    .slot_power_limit_mw(mw));
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    pcr_host_model_inst.xfer(1'h0, a, r);
    chk(r, {1'h1, e});
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    reset = 1'h0;
    chk(33'({sc, val, mw}), 33'h0_0000_0000);
    rd(8'h70, 32'h0072_0010);
    rd(8'h74, 32'h0000_8d82);
    rd(8'h7c, 32'h0000_0000);
    for (int s = 0; s < 4; s++)
    begin
      v = 8'hff - 8'(s) * 8'h55;
      pcr_host_model_inst.msg({22'h3f_ffff, 2'(s), v});
      chk(33'({sc, val, mw}), 33'({2'(s), v, 18'(v * mul[s])}));
      rd(8'h77, {4'h0, 2'(s), v, 18'h0_8d82});
    end
    pcr_host_model_inst.xfer(1'h1, 8'h74, r);
    chk(r, 33'h1_0000_0000);
    rd(8'h74, 32'h0c00_8d82);
    @(negedge clk);
    reset = 1'h1;
    @(negedge clk);
    reset = 1'h0;
    chk(33'({sc, val, mw}), 33'h0_0000_0000);
    rd(8'h74, 32'h0000_8d82);
    end_sim();
  end
  initial
  begin
    #100000;
    mismatches++;
    end_sim();
  end
endmodule // test_pcr_cap_regs
